// ---- src/sasp_params.svh ----
// Timing, default and field constants for the soft asynchronous serial port.
`ifndef SASP_PARAMS_SVH
`define SASP_PARAMS_SVH
`define SASP_CLK_HZ          125000000
`define SASP_DEF_BAUD        16'h2580
`define SASP_DEF_TIMEOUT_MS  16'h2710
`define SASP_DEF_PACE_US     16'h0000
`define SASP_DEF_WIDTH       4'h8
`define SASP_DEF_INVERT      1'b1
`define SASP_MIN_WIDTH       4'h4
`define SASP_MAX_WIDTH       4'h9
`define SASP_US_NS           1000
`define SASP_CYC_NS          8
`define SASP_US_CYCLES       (`SASP_US_NS / `SASP_CYC_NS)
`define SASP_MS_US           1000
`endif

// ---- src/sasp_pkg.sv ----
// Types shared by the soft asynchronous serial port.
package sasp_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
    } sasp_rx_word_t;

    typedef struct packed {
        logic        tx_invert;
        logic        rx_invert;
        logic [15:0] baud;
        logic [15:0] pace_us;
        logic [15:0] timeout_ms;
        logic [3:0]  width;
        logic        parity_en;
    } sasp_cfg_t;
endpackage

// ---- src/sasp_skid.sv ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sasp_skid (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   in_valid_i,
    output logic                        in_ready_o,
    input  wire sasp_pkg::sasp_rx_word_t in_data_i,
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output var sasp_pkg::sasp_rx_word_t out_data_o
);
    import sasp_pkg::*;

    sasp_rx_word_t mem_q [2];
    logic          wr_q;
    logic          rd_q;
    logic [1:0]    cnt_q;
    logic          push;
    logic          pop;

    assign push        = in_valid_i && (cnt_q != 2'h2);
    assign pop         = (cnt_q != 2'h0) && out_ready_i;
    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// ---- src/sasp_top.sv ----
// Soft asynchronous serial port: transmitter and receiver.
// Overview of operation
// [R01] The transmit line is inverted when tx_invert is 1 and true when 0.
// [R02] The receive line has its own polarity setting, 1 inverted, 0 true.
// [R03] Both directions share one bit rate, 9600 baud when set to zero.
// [R04] An optional gap in microseconds follows each sent character.
// [R05] The receiver reports a timeout if no start bit comes in time.
// [R06] A zero timeout makes the receiver wait for a start bit forever.
// [R07] The width setting spans 4 to 9 bits and parity is off by default; with parity off the code treats a width of 9 as 8.
// [R08] With parity on, one of the width bits carries parity, except at width 4, where parity follows 4 data bits.
// [R09] With parity on, a width of 9 carries 8 data bits plus parity.
// [R10] The transmitter sends even parity over data and parity bit.
// [R11] The receiver checks even parity and flags a mismatch.
// [R12] A frame is start, data LSB first, optional parity, one stop bit.
`timescale 1ns/1ps
`default_nettype none
`include "sasp_params.svh"
module sasp_top (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire sasp_pkg::sasp_cfg_t cfg_i,
    input  wire logic                tx_valid_i,
    input  wire logic [7:0]          tx_data_i,
    output logic                     tx_ready_o,
    output logic                     tx_line_o,
    input  wire logic                rx_line_i,
    input  wire logic                rx_enable_i,
    output logic                     rx_valid_o,
    output logic [7:0]               rx_data_o,
    output logic                     rx_parity_err_o,
    input  wire logic                rx_ready_i,
    output logic                     rx_timeout_o
);
    import sasp_pkg::*;

    typedef enum {SASP_TX_IDLE, SASP_TX_SHIFT, SASP_TX_PACE} sasp_tx_st_t;
    typedef enum {SASP_RX_IDLE, SASP_RX_WAIT, SASP_RX_SHIFT,
                  SASP_RX_PUSH} sasp_rx_st_t;

    // Cycles per bit; a zero rate falls back to the default rate.
    function automatic logic [31:0] bit_cycles(input logic [15:0] baud);
        logic [15:0] b;
        b = (baud == 16'h0000) ? `SASP_DEF_BAUD : baud;
        bit_cycles = 32'(`SASP_CLK_HZ / b);
    endfunction

    // Data bits in a frame for the given width and parity setting.
    function automatic logic [3:0] data_bits(input logic [3:0] w,
                                             input logic       p);
        logic [3:0] c;
        c = (w < `SASP_MIN_WIDTH) ? `SASP_MIN_WIDTH :
            (w > `SASP_MAX_WIDTH) ? `SASP_MAX_WIDTH : w;
        if (!p && c == `SASP_MAX_WIDTH) begin
            c = `SASP_DEF_WIDTH;
        end
        data_bits = p ? c - 4'h1 : c;
        if (p && c == `SASP_MIN_WIDTH) begin
            data_bits = `SASP_MIN_WIDTH;
        end
    endfunction

    function automatic logic even_par(input logic [7:0] d,
                                      input logic [3:0] n);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n) begin
                r = r ^ d[i];
            end
        end
        even_par = r;
    endfunction

    logic [31:0] bit_len;
    logic [3:0]  ndata;
    logic [3:0]  nframe;
    logic [3:0]  rx_pos;
    logic        tx_par;
    assign bit_len = bit_cycles(cfg_i.baud); // [R03]
    assign ndata   = data_bits(cfg_i.width, // [R07] [R08]
                               cfg_i.parity_en); // [R09]
    assign nframe  = ndata + 4'(cfg_i.parity_en);
    // Received character bits end at the top of the shift register.
    assign rx_pos  = 4'h9 - nframe;
    assign tx_par  = cfg_i.parity_en ? even_par(tx_data_i, ndata) // [R10]
                                     : 1'b1;

    // Transmitter.
    sasp_tx_st_t tx_st_q;
    logic [10:0] tx_sh_q;
    logic [3:0]  tx_left_q;
    logic [31:0] tx_cnt_q;
    logic [15:0] tx_us_q;
    logic [31:0] tx_sub_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_st_q    <= SASP_TX_IDLE;
            tx_sh_q    <= '1;
            tx_left_q  <= 4'h0;
            tx_cnt_q   <= 32'h0;
            tx_us_q    <= 16'h0;
            tx_sub_q   <= 32'h0;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= 1'b0;
            case (tx_st_q)
                SASP_TX_IDLE: begin
                    tx_ready_o <= 1'b1;
                    if (tx_valid_i && tx_ready_o) begin
                        tx_ready_o <= 1'b0;
                        // Stop, parity, data LSB first, start.
                        tx_sh_q <= (11'h7FF << (nframe + 4'h1)) // [R12]
                                 | (11'(tx_par) << (ndata + 4'h1))
                                 | (11'(tx_data_i & ~(8'hFF << ndata)) << 1);
                        tx_left_q <= nframe + 4'h2;
                        tx_cnt_q  <= bit_len;
                        tx_st_q   <= SASP_TX_SHIFT;
                    end
                end
                SASP_TX_SHIFT: begin
                    if (tx_cnt_q <= 32'h1) begin
                        tx_cnt_q  <= bit_len;
                        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                        tx_left_q <= tx_left_q - 4'h1;
                        if (tx_left_q == 4'h1) begin
                            tx_us_q  <= cfg_i.pace_us; // [R04]
                            tx_sub_q <= `SASP_US_CYCLES;
                            tx_st_q  <= SASP_TX_PACE;
                        end
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 32'h1;
                    end
                end
                SASP_TX_PACE: begin
                    if (tx_us_q == 16'h0) begin
                        tx_st_q <= SASP_TX_IDLE;
                    end else if (tx_sub_q <= 32'h1) begin
                        tx_sub_q <= `SASP_US_CYCLES;
                        tx_us_q  <= tx_us_q - 16'h1;
                    end else begin
                        tx_sub_q <= tx_sub_q - 32'h1;
                    end
                end
                default: tx_st_q <= SASP_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_line_o <= 1'b0;
        end else begin
            tx_line_o <= (tx_st_q == SASP_TX_SHIFT ? tx_sh_q[0] : 1'b1)
                         ^ cfg_i.tx_invert; // [R01]
        end
    end

    // Receiver.
    sasp_rx_st_t   rx_st_q;
    logic          rx_bit;
    logic [31:0]   rx_cnt_q;
    logic [3:0]    rx_left_q;
    logic [8:0]    rx_sh_q;
    logic [15:0]   rx_ms_q;
    logic [31:0]   rx_sub_q;
    logic          push_valid_q;
    logic          push_ready;
    sasp_rx_word_t push_word_q;
    logic          out_valid;
    sasp_rx_word_t out_word;

    assign rx_bit = rx_line_i ^ cfg_i.rx_invert; // [R02]

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_st_q      <= SASP_RX_IDLE;
            rx_cnt_q     <= 32'h0;
            rx_left_q    <= 4'h0;
            rx_sh_q      <= 9'h0;
            rx_ms_q      <= 16'h0;
            rx_sub_q     <= 32'h0;
            rx_timeout_o <= 1'b0;
            push_valid_q <= 1'b0;
            push_word_q  <= '0;
        end else begin
            rx_timeout_o <= 1'b0;
            case (rx_st_q)
                SASP_RX_IDLE: begin
                    if (rx_enable_i) begin
                        rx_ms_q  <= cfg_i.timeout_ms;
                        rx_sub_q <= `SASP_US_CYCLES * `SASP_MS_US;
                        rx_st_q  <= SASP_RX_WAIT;
                    end
                end
                SASP_RX_WAIT: begin
                    if (!rx_bit) begin
                        // Sample start bit mid-cell, then each data and parity bit mid-cell; the stop bit is not sampled.
                        rx_cnt_q  <= bit_len >> 1;
                        rx_left_q <= nframe + 4'h2;
                        rx_st_q   <= SASP_RX_SHIFT;
                    end else if (cfg_i.timeout_ms != 16'h0) begin // [R06]
                        if (rx_sub_q <= 32'h1) begin
                            rx_sub_q <= `SASP_US_CYCLES * `SASP_MS_US;
                            rx_ms_q  <= rx_ms_q - 16'h1;
                            if (rx_ms_q <= 16'h1) begin
                                rx_timeout_o <= 1'b1; // [R05]
                                rx_st_q      <= SASP_RX_IDLE;
                            end
                        end else begin
                            rx_sub_q <= rx_sub_q - 32'h1;
                        end
                    end
                end
                SASP_RX_SHIFT: begin
                    if (rx_cnt_q <= 32'h1) begin
                        rx_cnt_q  <= bit_len;
                        rx_left_q <= rx_left_q - 4'h1;
                        if (rx_left_q == 4'h1) begin
                            rx_st_q <= SASP_RX_PUSH;
                        end else begin
                            rx_sh_q <= {rx_bit, rx_sh_q[8:1]}; // [R12]
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 32'h1;
                    end
                end
                SASP_RX_PUSH: begin
                    // Shifted word sits at the top of the register.
                    if (!push_valid_q || push_ready) begin
                        push_valid_q <= 1'b1;
                        push_word_q.data <= 8'((rx_sh_q >> rx_pos)
                            & ~(9'h1FF << ndata));
                        push_word_q.parity_err <= cfg_i.parity_en &&
                            (even_par(8'(rx_sh_q >> rx_pos), ndata)
                             != rx_sh_q[8]); // [R11]
                        rx_st_q <= SASP_RX_IDLE;
                    end
                end
                default: rx_st_q <= SASP_RX_IDLE;
            endcase
            if (push_valid_q && push_ready && rx_st_q != SASP_RX_PUSH) begin
                push_valid_q <= 1'b0;
            end
        end
    end

    sasp_skid u_buf (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_valid_q),
        .in_ready_o  (push_ready),
        .in_data_i   (push_word_q),
        .out_valid_o (out_valid),
        .out_ready_i (rx_ready_i && !rx_valid_o),
        .out_data_o  (out_word)
    );

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_valid_o      <= 1'b0;
            rx_data_o       <= 8'h00;
            rx_parity_err_o <= 1'b0;
        end else if (rx_valid_o) begin
            rx_valid_o <= 1'b0;
        end else if (out_valid && rx_ready_i) begin
            rx_valid_o      <= 1'b1;
            rx_data_o       <= out_word.data;
            rx_parity_err_o <= out_word.parity_err;
        end
    end
endmodule
`default_nettype wire

// ---- tb/sasp_checker.sv ----
// Concurrent checks on the ports of the soft asynchronous serial port.
`timescale 1ns/1ps
`default_nettype none
module sasp_checker (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire sasp_pkg::sasp_cfg_t cfg_i,
    input wire logic                tx_valid_i,
    input wire logic [7:0]          tx_data_i,
    input wire logic                tx_ready_o,
    input wire logic                tx_line_o,
    input wire logic                rx_line_i,
    input wire logic                rx_enable_i,
    input wire logic                rx_valid_o,
    input wire logic [7:0]          rx_data_o,
    input wire logic                rx_parity_err_o,
    input wire logic                rx_ready_i,
    input wire logic                rx_timeout_o
);
    import sasp_pkg::*;
    // Shortest legal frame: six bits at the fastest rate the field holds.
    localparam int MIN_FRAME = 11442;
    int unsigned busy_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Counts only from a taken character, so the first rise of ready after
    // reset is not mistaken for the end of a frame.
    always_ff @(posedge clk_i) begin
        if (reset_i || (tx_ready_o && !tx_valid_i)) begin
            busy_q <= 0;
        end else if (tx_ready_o) begin
            busy_q <= 1;
        end else if (busy_q != 0) begin
            busy_q <= busy_q + 1;
        end
    end
    AST_TX_IDLE: assert property (
        tx_ready_o && $stable(cfg_i.tx_invert) |-> tx_line_o == !cfg_i.tx_invert)
        else $error("Idle transmit level is wrong.");
    AST_TX_START: assert property (
        tx_valid_i && tx_ready_o |=> !tx_ready_o ##1 tx_line_o == cfg_i.tx_invert)
        else $error("Start bit missing after a taken character.");
    AST_FRAME_LEN: assert property (
        $rose(tx_ready_o) && busy_q != 0 |-> busy_q >= MIN_FRAME)
        else $error("Transmitter came back before a whole frame.");
    AST_RX_ERR_HOLD: assert property (
        $changed(rx_parity_err_o) |-> rx_valid_o)
        else $error("Parity flag moved without a new word.");
    AST_RX_DATA_HOLD: assert property (
        $changed(rx_data_o) |-> rx_valid_o)
        else $error("Received data moved without a new word.");
    AST_RX_PULSE: assert property (
        rx_valid_o |=> !rx_valid_o)
        else $error("Receive valid lasted more than one cycle.");
    AST_TO_OFF: assert property (
        cfg_i.timeout_ms == 16'h0000 |-> !rx_timeout_o)
        else $error("Timeout reported while waiting forever.");
    AST_TO_PULSE: assert property (
        rx_timeout_o |=> !rx_timeout_o)
        else $error("Timeout lasted more than one cycle.");
    cover property (tx_valid_i && tx_ready_o);
    cover property (rx_valid_o && rx_parity_err_o);
    cover property (rx_valid_o && !rx_parity_err_o);
endmodule
bind sasp_top sasp_checker sasp_checker_inst (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i),
    .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
    .tx_ready_o(tx_ready_o), .tx_line_o(tx_line_o),
    .rx_line_i(rx_line_i), .rx_enable_i(rx_enable_i),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_parity_err_o(rx_parity_err_o), .rx_ready_i(rx_ready_i),
    .rx_timeout_o(rx_timeout_o)
);
`default_nettype wire

// ---- tb/sasp_peer.sv ----
// Serial peer model: decodes the port's output, drives the port's input.
`timescale 1ns/1ps
`default_nettype none
module sasp_peer #(
    parameter int BIT_CYC = 2000
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output var logic  line_o
);
    initial line_o = 1'b0;
    // Idle is logic one; inversion swaps every level on the line.
    task automatic idle(input logic inv);
        line_o <= !inv;
    endtask
    task automatic put(input logic [10:0] f, input int n, input logic inv);
        for (int i = -1; i < n; i++) begin
            @(posedge clk_i);
            line_o <= (i < 0) ? inv : f[i] ^ inv;
            repeat (BIT_CYC - 1) @(posedge clk_i);
        end
    endtask
    // Samples mid-bit so a few cycles of skew in the port do no harm.
    task automatic get(input int n, input logic inv, output logic [10:0] f);
        f = '0;
        @(posedge clk_i);
        while (line_i !== inv) @(posedge clk_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYC) @(posedge clk_i);
            f[i] = line_i ^ inv;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/soft_async_serial_port_bench.sv ----
// Self-checking bench for the soft asynchronous serial port.
`timescale 1ns/1ps
`default_nettype none
module soft_async_serial_port_bench;
    import sasp_pkg::*;
    localparam int BIT_CYC = 2000;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    sasp_cfg_t  cfg = '{1'b1, 1'b1, 16'hF424, 16'h0, 16'h0, 4'h8, 1'b0};
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       rx_en = 1'b0;
    logic       rx_rdy = 1'b1;
    logic       tx_ready, tx_line, rx_line, rx_valid, rx_err, rx_to;
    logic [7:0] rx_data;
    int         bad_count = 0;
    int         n_checks = 0;
    sasp_top sasp_top_inst (
        .clk_i(clk), .reset_i(rst), .cfg_i(cfg), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(tx_ready), .tx_line_o(tx_line),
        .rx_line_i(rx_line), .rx_enable_i(rx_en), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_parity_err_o(rx_err),
        .rx_ready_i(rx_rdy), .rx_timeout_o(rx_to));
    sasp_peer #(.BIT_CYC(BIT_CYC)) sasp_peer_inst (
        .clk_i(clk), .line_i(tx_line), .line_o(rx_line));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [10:0] frm(input logic [7:0] d, input int nd,
                                        input logic pe, input logic flip);
        logic p;
        frm = '0;
        p = 1'b0;
        for (int i = 0; i < nd; i++) begin
            frm[i] = d[i];
            p = p ^ d[i];
        end
        if (pe) frm[nd] = p ^ flip;
        frm[nd + pe] = 1'b1;
    endfunction
    task automatic send(input logic [7:0] d);
        tx_valid <= 1'b1;
        tx_data <= d;
        do @(posedge clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
    endtask
    task automatic phase(input logic ti, ri, input logic [3:0] w,
                         input logic pe, input logic [15:0] pace,
                         input logic [7:0] td, rd, input logic flip, stall);
        int nd;
        int nb;
        int n;
        int k;
        logic [10:0] got;
        nd = pe ? ((w == 4'h9) ? 8 : w - 1) : w;
        nb = nd + pe + 1;
        rx_en <= 1'b0;
        rx_rdy <= !stall;
        cfg <= '{ti, ri, 16'hF424, pace, 16'h0000, w, pe};
        sasp_peer_inst.idle(ri);
        repeat (4) @(posedge clk);
        rx_en <= 1'b1;
        repeat (4) @(posedge clk);
        fork
            begin
                send(td);
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                end while (tx_ready !== 1'b1 && n < 40000);
                k = (nb + 1) * BIT_CYC + pace * 125;
                check(n >= k && n < k + 8, 1'b1);
            end
            begin
                sasp_peer_inst.get(nb, ti, got);
                check(got, frm(td, nd, pe, 1'b0));
            end
            begin
                sasp_peer_inst.put(frm(rd, nd, pe, flip), nb, ri);
                repeat (100) @(posedge clk);
                rx_rdy <= 1'b1;
            end
            begin
                for (int i = 0; i < 40000 && rx_valid !== 1'b1; i++)
                    @(posedge clk);
                check(rx_valid, 1'b1);
                check(rx_rdy, 1'b1);
                check(rx_data, rd);
                check(rx_err, flip);
                check(rx_to, 1'b0);
            end
        join
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(tx_ready, 1'b1);
        check(tx_line, 1'b0);
        phase(1'b1, 1'b0, 4'h8, 1'b0, 16'h0000, 8'hA5, 8'h5A, 1'b0, 1'b0);
        phase(1'b0, 1'b1, 4'h9, 1'b1, 16'h0004, 8'h97, 8'h3C, 1'b1, 1'b0);
        phase(1'b1, 1'b1, 4'h5, 1'b1, 16'h0002, 8'h0B, 8'h06, 1'b0, 1'b1);
        conclude();
    end
    // The three frames take about 60000 cycles; stop well beyond that.
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire
